// ---- amttr_far_model.sv ----
/*
 * Sensor front-end model: live readings, fault levels, thermal pin.
 * Assumes the bench sets targets; outputs move just after pclk edges.
 */
`timescale 1ns/1ps
module amttr_far_model
	import amttr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire amttr_meas_t meas_want,
	input wire amttr_fault_t fault_want,
	input wire logic pin_want_n,
	output amttr_meas_t meas,
	output amttr_fault_t fault,
	output logic thermal_pin_n
);
	// Registered, so the block never sees a change on its own edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meas <= '0;
			fault <= '0;
			thermal_pin_n <= 1'b1;
		end else begin
			meas <= meas_want;
			fault <= fault_want;
			thermal_pin_n <= pin_want_n;
		end
	end
endmodule : amttr_far_model

// ---- amttr_pkg.sv ----
/*
 * Package for the alert mask, low-bit readback and thermal timer bank:
 * register indices, field positions, reset values, timing and carriers.
 * Assumes a 125 MHz pclk and an APB master with 32-bit data.
 */
package amttr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MASK_CH = 8'h74;
	localparam logic [7:0] IDX_MASK_FLT = 8'h75;
	localparam logic [7:0] IDX_VOLT_LOW = 8'h76;
	localparam logic [7:0] IDX_TEMP_LOW = 8'h77;
	localparam logic [7:0] IDX_CFG3 = 8'h78;
	localparam logic [7:0] IDX_DURATION = 8'h79;
	localparam logic [7:0] IDX_LIMIT = 8'h7a;
	localparam logic [7:0] IDX_CTRL = 8'h80;
	localparam logic [7:0] IDX_EVENT = 8'h81;
	// Five high-byte registers follow: cpu, main, remote1, local, remote2
	localparam logic [7:0] IDX_HIGH_BASE = 8'h82;
	localparam int NUM_CHAN = 5;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int M1_SUPPLY_CPU = 1;
	localparam int M1_SUPPLY_MAIN = 2;
	localparam int M1_REMOTE_ONE = 4;
	localparam int M1_LOCAL = 5;
	localparam int M1_REMOTE_TWO = 6;
	localparam int M1_STATUS_TWO = 7;
	localparam int M2_OVERTEMP = 1;
	localparam int M2_ROTOR_LSB = 2;
	localparam int M2_ROTOR_FOUR = 5;
	localparam int M2_DIODE_ONE = 6;
	localparam int M2_DIODE_TWO = 7;
	localparam int C3_ALERT_EN = 0;
	localparam int C3_THERMAL_PIN_EN = 1;
	localparam int C3_BOOST = 2;
	localparam int C3_FAST = 3;
	localparam int C3_STEADY_LSB = 4;
	localparam int CTRL_LOCK = 0;
	localparam int CTRL_PINFUNC_LSB = 1;
	localparam logic [7:0] MASK1_WRITABLE = 8'hf6;
	localparam logic [7:0] MASK2_WRITABLE = 8'hfc;
	localparam logic [1:0] PIN_FUNC_THERMAL = 2'h1;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [7:0] CFG3_RESET = 8'h00;
	localparam logic [7:0] DURATION_RESET = 8'h00;
	localparam logic [7:0] LIMIT_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int STEP_TIME_NS = 22760000;
	localparam int FIRST_TIME_NS = 45520000;
	localparam int TACH_FAST_NS = 250000000;
	localparam int TACH_SLOW_NS = 1000000000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
	localparam int FIRST_STEPS = FIRST_TIME_NS / STEP_TIME_NS;
	localparam int TACH_FAST_CYCLES = TACH_FAST_NS / CLK_PERIOD_NS;
	localparam int TACH_SLOW_CYCLES = TACH_SLOW_NS / CLK_PERIOD_NS;
	localparam int STEP_W = 22;
	localparam int TACH_W = 27;

	////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} amttr_apb_req_t;

	// Channel order: cpu, main, remote1, local, remote2
	typedef logic [NUM_CHAN-1:0][9:0] amttr_meas_t;

	typedef struct packed {
		logic supply_cpu;
		logic supply_main;
		logic remote_one;
		logic local_temp;
		logic remote_two;
		logic overtemp;
		logic [3:0] rotor;
		logic diode_one;
		logic diode_two;
	} amttr_fault_t;

	typedef struct packed {
		logic boost;
		logic fast;
		logic [3:0] steady_drive;
		logic tach_measure;
	} amttr_fan_ctl_t;

	typedef enum logic {TM_IDLE, TM_ASSERT} amttr_tmr_state_t;

	typedef struct packed {
		logic [7:0] mask_ch;
		logic [7:0] mask_flt;
		logic [7:0] cfg3;
		logic [7:0] limit;
		logic lock;
		logic [1:0] pin_func;
		logic [NUM_CHAN-1:0] pend;
		amttr_meas_t snap;
		amttr_tmr_state_t tstate;
		logic seen;
		logic [7:0] dur;
		logic [STEP_W-1:0] step_cnt;
		logic limit_flag;
		logic [TACH_W-1:0] tach_cnt;
		logic tach_pulse;
		logic [31:0] prdata;
		logic slverr;
		logic alert_n;
		logic boost;
	} amttr_state_t;

endpackage : amttr_pkg

// ---- amttr_regs.sv ----
/*
 * Alert mask, low-bit readback and thermal timer register bank, APB slave.
 * Assumes measurements and fault levels arrive synchronous to pclk and
 * that the thermal pin input is already synchronised, active low.
 */
// Register access over APB is this design's own decision.
// Function
// - Channel mask bits keep voltage and temperature faults off the alert.
// - Top bit of first mask blocks every second-status fault.
// - Three fan mask bits suppress alert for fans one to three.
// - Fan-four mask bit masks timer event when pin is thermal input.
// - Two diode mask bits suppress open or short diode alerts.
// - Overtemperature mask bit gates alert, read-only to host.
// - Both mask registers reset to zero.
// - Voltage low-bits register shows cpu bits 3:2, main bits 5:4.
// - Temperature low-bits register shows remote1, local, remote2 pairs.
// - Reading low bits freezes them and high bytes until highs read.
// - Alert-enable bit turns the shared pin into the alert output.
// - Thermal-enable bit with pin function enables assertion timing.
// - Boost bit drives fans to maximum while thermal input asserted.
// - Four steady-drive bits select continuous tach measurement.
// - Lock bit makes third configuration register ignore writes.
// - Timer bit zero sets on assertion, clears on host read.
// - Upper timer bits zero until 45.52 ms, then 22.76 ms steps.
// - Past first threshold bit zero is LSB of 8-bit count.
// - Third configuration and timer status reset to zero.
// - Assertion time above limit sets timer flag; zero limit is immediate.
`timescale 1ns/1ps
module amttr_regs
	import amttr_pkg::*;
#(
	parameter int STEP_CYC = STEP_CYCLES,
	parameter int TACH_FAST_CYC = TACH_FAST_CYCLES,
	parameter int TACH_SLOW_CYC = TACH_SLOW_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pclk_en,
	input wire amttr_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire amttr_meas_t meas,
	input wire amttr_fault_t fault,
	input wire logic thermal_pin_n,
	output logic alert_mode,
	output logic alert_n,
	output amttr_fan_ctl_t fan_ctl,
	output amttr_meas_t high_frozen
);

	////////////////////////////////////////////////////////////////////////
	// Elaboration checks
	if (STEP_CYC < 1 || STEP_CYC >= 2 ** STEP_W) begin : g_bad_step
		$error("step cycle count out of range");
	end
	if (TACH_FAST_CYC < 1 || TACH_SLOW_CYC >= 2 ** TACH_W ||
		TACH_FAST_CYC > TACH_SLOW_CYC) begin : g_bad_tach
		$error("tach period out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		return a == {2'b00, idx, 2'b00};
	endfunction : hit

	function automatic logic [7:0] duration_view(input amttr_state_t s);
		// Count shows only once past the first threshold
		if (s.dur >= 8'(FIRST_STEPS))
			return s.dur;
		return {7'h00, s.seen};
	endfunction : duration_view

	function automatic logic [8:0] read_word(input logic [11:0] a,
		input amttr_state_t s);
		logic [8:0] r;
		r = {1'b1, 8'h00};
		if (hit(a, IDX_MASK_CH))
			r = {1'b0, s.mask_ch};
		else if (hit(a, IDX_MASK_FLT))
			r = {1'b0, s.mask_flt};
		else if (hit(a, IDX_VOLT_LOW))
			r = {3'h0, s.snap[1][1:0], s.snap[0][1:0], 2'h0};
		else if (hit(a, IDX_TEMP_LOW))
			r = {1'b0, s.snap[4][1:0], s.snap[3][1:0], s.snap[2][1:0], 2'h0};
		else if (hit(a, IDX_CFG3))
			r = {1'b0, s.cfg3};
		else if (hit(a, IDX_DURATION))
			r = {1'b0, duration_view(s)};
		else if (hit(a, IDX_LIMIT))
			r = {1'b0, s.limit};
		else if (hit(a, IDX_CTRL))
			r = {6'h00, s.pin_func, s.lock};
		else if (hit(a, IDX_EVENT))
			r = {5'h00, s.tstate == TM_ASSERT, s.boost, ~s.alert_n,
				s.limit_flag};
		else
			for (int k = 0; k < NUM_CHAN; k++)
				if (hit(a, IDX_HIGH_BASE + 8'(k)))
					r = {1'b0, s.snap[k][9:2]};
		return r;
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////
	// State
	amttr_state_t st_reg;
	amttr_state_t st_next;
	logic setup_rd;
	logic acc;
	logic wr;
	logic rd;
	logic thermal_pin_mode;
	logic thermal_pin_active;
	logic timer_event;
	logic status_one_alert;
	logic status_two_alert;
	logic rotor_four_src;
	logic [7:0] wbyte;
	logic [8:0] rword;
	logic [7:0] dur_view;

	assign acc = apb_req.psel && apb_req.penable && pclk_en;
	assign wr = acc && apb_req.pwrite;
	assign rd = acc && !apb_req.pwrite;
	assign setup_rd = apb_req.psel && !apb_req.penable && pclk_en;
	assign wbyte = apb_req.pwdata[7:0];
	assign rword = read_word(apb_req.paddr, st_reg);
	// Host view of the duration register, watched by the assertions
	assign dur_view = duration_view(st_reg);

	// timing only with enable and thermal pin function
	assign thermal_pin_mode = st_reg.cfg3[C3_THERMAL_PIN_EN] &&
		st_reg.pin_func == PIN_FUNC_THERMAL;
	assign thermal_pin_active = thermal_pin_mode && !thermal_pin_n;

	// zero limit flags at once, else when count exceeds limit
	assign timer_event = thermal_pin_active &&
		(st_reg.limit == LIMIT_RESET || st_reg.dur > st_reg.limit);

	// fan-four mask covers timer event in thermal mode
	assign rotor_four_src = thermal_pin_mode ? st_reg.limit_flag : fault.rotor[3];

	assign status_one_alert =
		(fault.supply_cpu && !st_reg.mask_ch[M1_SUPPLY_CPU]) ||
		(fault.supply_main && !st_reg.mask_ch[M1_SUPPLY_MAIN]) ||
		(fault.remote_one && !st_reg.mask_ch[M1_REMOTE_ONE]) ||
		(fault.local_temp && !st_reg.mask_ch[M1_LOCAL]) ||
		(fault.remote_two && !st_reg.mask_ch[M1_REMOTE_TWO]);

	assign status_two_alert = !st_reg.mask_ch[M1_STATUS_TWO] && (
		(fault.overtemp && !st_reg.mask_flt[M2_OVERTEMP]) ||
		|(fault.rotor[2:0] & ~st_reg.mask_flt[M2_ROTOR_LSB +: 3]) ||
		(rotor_four_src && !st_reg.mask_flt[M2_ROTOR_FOUR]) ||
		(fault.diode_one && !st_reg.mask_flt[M2_DIODE_ONE]) ||
		(fault.diode_two && !st_reg.mask_flt[M2_DIODE_TWO]));

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next = st_reg;
		if (pclk_en) begin
			// Read data from flops: captured in the setup cycle
			if (setup_rd) begin
				st_next.prdata = apb_req.pwrite ? 32'h0 : {24'h0, rword[7:0]};
				st_next.slverr = rword[8];
			end

			// Register writes
			if (wr) begin
				if (hit(apb_req.paddr, IDX_MASK_CH))
					st_next.mask_ch = wbyte & MASK1_WRITABLE;
				if (hit(apb_req.paddr, IDX_MASK_FLT))
					st_next.mask_flt = wbyte & MASK2_WRITABLE;
				if (hit(apb_req.paddr, IDX_CFG3) && !st_reg.lock)
					st_next.cfg3 = wbyte;
				if (hit(apb_req.paddr, IDX_LIMIT))
					st_next.limit = wbyte;
				if (hit(apb_req.paddr, IDX_CTRL)) begin
					// Lock is sticky until reset
					st_next.lock = st_reg.lock || wbyte[CTRL_LOCK];
					st_next.pin_func = wbyte[CTRL_PINFUNC_LSB +: 2];
				end
			end

			// freeze groups on low-bit read, release a group once all its high bytes are read
			if (rd) begin
				if (hit(apb_req.paddr, IDX_VOLT_LOW))
					st_next.pend[1:0] = 2'h3;
				if (hit(apb_req.paddr, IDX_TEMP_LOW))
					st_next.pend[4:2] = 3'h7;
				for (int k = 0; k < NUM_CHAN; k++)
					if (hit(apb_req.paddr, IDX_HIGH_BASE + 8'(k)))
						st_next.pend[k] = 1'b0;
			end
			for (int k = 0; k < NUM_CHAN; k++) begin
				if (k < 2 ? st_reg.pend[1:0] == 2'h0
					: st_reg.pend[4:2] == 3'h0)
					st_next.snap[k] = meas[k];
			end

			// bit zero cleared by read; count cleared when idle
			if (rd && hit(apb_req.paddr, IDX_DURATION)) begin
				st_next.seen = st_reg.seen && !st_reg.prdata[0];
				if (st_reg.tstate == TM_IDLE)
					st_next.dur = DURATION_RESET;
			end

			// Thermal timer
			case (st_reg.tstate)
				TM_IDLE: begin
					if (thermal_pin_active) begin
						st_next.tstate = TM_ASSERT;
						st_next.dur = DURATION_RESET;
						st_next.step_cnt = '0;
					end
				end
				TM_ASSERT: begin
					if (!thermal_pin_active) begin
						st_next.tstate = TM_IDLE;
					end else if (st_reg.step_cnt == STEP_W'(STEP_CYC - 1)) begin
						st_next.step_cnt = '0;
						// steps of 22.76 ms, saturating at eight bits
						if (st_reg.dur != 8'hff)
							st_next.dur = st_reg.dur + 8'h01;
					end else begin
						st_next.step_cnt = st_reg.step_cnt + STEP_W'(1);
					end
				end
				default: st_next.tstate = TM_IDLE;
			endcase
			// set on assertion wins over a clearing read
			if (thermal_pin_active)
				st_next.seen = 1'b1;

			// sticky flag, set wins over clear by event read
			if (rd && hit(apb_req.paddr, IDX_EVENT))
				st_next.limit_flag = st_reg.limit_flag && !st_reg.prdata[0];
			if (timer_event)
				st_next.limit_flag = 1'b1;

			// fail-safe boost while thermal input asserted
			st_next.boost = st_reg.cfg3[C3_BOOST] && thermal_pin_active;

			st_next.tach_pulse = 1'b0;
			if (st_reg.tach_cnt == '0) begin
				st_next.tach_pulse = 1'b1;
				st_next.tach_cnt = st_reg.cfg3[C3_FAST]
					? TACH_W'(TACH_FAST_CYC - 1) : TACH_W'(TACH_SLOW_CYC - 1);
			end else begin
				st_next.tach_cnt = st_reg.tach_cnt - TACH_W'(1);
			end

			// active-low alert only in alert mode
			st_next.alert_n = !(st_reg.cfg3[C3_ALERT_EN] &&
				(status_one_alert || status_two_alert));
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// zero masks, configuration and timer status
			st_reg <= '{mask_ch: MASK_RESET, mask_flt: MASK_RESET,
				cfg3: CFG3_RESET, limit: LIMIT_RESET, dur: DURATION_RESET,
				tstate: TM_IDLE, alert_n: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign pready = acc;
	assign prdata = st_reg.prdata;
	assign pslverr = acc && st_reg.slverr;
	assign alert_mode = st_reg.cfg3[C3_ALERT_EN];
	assign alert_n = st_reg.alert_n;
	assign fan_ctl.boost = st_reg.boost;
	assign fan_ctl.fast = st_reg.cfg3[C3_FAST];
	assign fan_ctl.steady_drive = st_reg.cfg3[C3_STEADY_LSB +: 4];
	assign fan_ctl.tach_measure = st_reg.tach_pulse;
	// Frozen high bytes feed the external reading registers
	assign high_frozen = st_reg.snap;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	sequence thermal_pin_rise_s;
		st_reg.tstate == TM_IDLE && thermal_pin_active && pclk_en;
	endsequence

	sequence step_wrap_s;
		st_reg.tstate == TM_ASSERT && thermal_pin_active && pclk_en &&
		st_reg.step_cnt == STEP_W'(STEP_CYC - 1) && st_reg.dur != 8'hff;
	endsequence

	alert_off_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && !st_reg.cfg3[C3_ALERT_EN] |=> alert_n)
		else $error("alert driven while alert mode off");

	all_masked_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && st_reg.mask_ch[7:4] == 4'hf &&
		st_reg.mask_ch[2:1] == 2'h3 |=> alert_n)
		else $error("alert asserted with every source masked");

	alert_unmasked_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && st_reg.cfg3[C3_ALERT_EN] && fault.supply_cpu &&
		!st_reg.mask_ch[M1_SUPPLY_CPU] |=> !alert_n)
		else $error("unmasked fault did not raise alert");

	overtemp_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
		!st_reg.mask_flt[M2_OVERTEMP] && !st_reg.mask_flt[0])
		else $error("read-only mask bit changed");

	lock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && st_reg.lock && hit(apb_req.paddr, IDX_CFG3) |=>
		$stable(st_reg.cfg3))
		else $error("locked configuration was written");

	seen_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		thermal_pin_rise_s |=> st_reg.seen ##0 st_reg.tstate == TM_ASSERT)
		else $error("assertion flag not set on thermal rise");

	step_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_wrap_s |=> st_reg.dur == $past(st_reg.dur) + 8'h01)
		else $error("duration count did not step");

	upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg.dur < 8'(FIRST_STEPS) |-> dur_view[7:1] == 7'h00)
		else $error("upper timer bits shown before threshold");

	zero_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
		thermal_pin_rise_s ##0 st_reg.limit == 8'h00 |=> st_reg.limit_flag)
		else $error("zero limit did not flag at once");

	boost_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		pclk_en && st_reg.cfg3[C3_BOOST] && thermal_pin_active |=> fan_ctl.boost)
		else $error("boost missing during thermal assertion");

	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_reg.pend[1:0] != 2'h0 |=> st_reg.snap[0] == $past(st_reg.snap[0]))
		else $error("frozen reading changed");

endmodule : amttr_regs

// ---- amttr_regs_tb.sv ----
/*
 * Self-checking bench for the alert mask and thermal timer bank.
 * Assumes the designer's contract: zero-wait APB, shortened timer counts.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
	failures++; $display("wrong value %s exp %h got %h", nm, ex, got); \
	end end
module amttr_regs_tb
	import amttr_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn;
	logic pclk_en;
	amttr_apb_req_t req;
	logic [31:0] prdata;
	logic pready, pslverr, alert_mode, alert_n, thermal_pin_n, pin_want_n;
	amttr_fan_ctl_t fan_ctl;
	amttr_meas_t high_frozen, meas, meas_want, m0, m1;
	amttr_fault_t fault, fault_want;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	int n;
	logic [64:0] exp_q[$];
	logic [7:0] v;
	// Mask bit for each fault bit, fault struct bit 0 first
	byte mb[12] = '{7, 6, 2, 3, 4, 5, 1, 6, 5, 4, 2, 1};

	always #4 pclk = ~pclk;

	amttr_regs #(.STEP_CYC(4), .TACH_FAST_CYC(8), .TACH_SLOW_CYC(32))
	i_amttr_regs (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en),
		.apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.meas(meas), .fault(fault), .thermal_pin_n(thermal_pin_n),
		.alert_mode(alert_mode), .alert_n(alert_n), .fan_ctl(fan_ctl),
		.high_frozen(high_frozen));

	amttr_far_model i_amttr_far_model (.pclk(pclk), .presetn(presetn),
		.meas_want(meas_want), .fault_want(fault_want),
		.pin_want_n(pin_want_n), .meas(meas), .fault(fault),
		.thermal_pin_n(thermal_pin_n));

	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	// Tests need about four hundred and twenty cycles; far more means a hang
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			test_done();
		end
	end

	// Answer watcher: oldest note against each completed transfer
	always @(posedge pclk) begin
		logic [64:0] e;
		if (req.psel && req.penable && pready === 1'b1) begin
			e = (exp_q.size() == 0) ? '1 : exp_q.pop_front();
			`CHK("pslverr", e[64], pslverr)
			`CHK("prdata", e[63:32] & e[31:0], prdata & e[31:0])
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [7:0] d, input logic [31:0] e, input logic [31:0] m,
		input logic se);
		exp_q.push_back({se, e, m});
		@(posedge pclk);
		req.psel <= 1'b1;
		req.pwrite <= w;
		req.paddr <= {2'h0, idx, 2'h0};
		req.pwdata <= {24'($urandom()), d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : xfer

	task automatic rd(input logic [7:0] idx, input logic [31:0] e,
		input logic [31:0] m);
		xfer(1'b0, idx, 8'h00, e, m, 1'b0);
	endtask : rd

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 32'h0, 32'h0, 1'b0);
	endtask : wr

	task automatic cyc(input int k);
		repeat (k) @(posedge pclk);
	endtask : cyc

	task automatic tach_period(output int k);
		k = 0;
		@(posedge pclk);
		while (fan_ctl.tach_measure !== 1'b1)
			@(posedge pclk);
		do begin
			@(posedge pclk);
			k++;
		end while (fan_ctl.tach_measure !== 1'b1);
	endtask : tach_period

	////////////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		pclk_en = 1'b1;
		req = '0;
		meas_want = '0;
		fault_want = '0;
		pin_want_n = 1'b1;
		void'($urandom(36748));
		cyc(5);
		presetn <= 1'b1;
		rd(IDX_MASK_CH, 32'h0, 32'hff);
		rd(IDX_MASK_FLT, 32'h0, 32'hff);
		rd(IDX_CFG3, 32'h0, 32'hff);
		rd(IDX_DURATION, 32'h0, 32'hff);
		`CHK("alert_n", 1'b1, alert_n)
		xfer(1'b0, 8'h7f, 8'h00, 32'h0, '1, 1'b1);
		xfer(1'b1, 8'h7b, 8'h5a, 32'h0, 32'h0, 1'b1);
		v = 8'($urandom());
		wr(IDX_MASK_CH, v);
		rd(IDX_MASK_CH, {24'h0, v & MASK1_WRITABLE}, 32'hff);
		wr(IDX_MASK_FLT, ~v);
		rd(IDX_MASK_FLT, {24'h0, ~v & MASK2_WRITABLE}, 32'hff);
		wr(IDX_MASK_CH, 8'h00);
		wr(IDX_MASK_FLT, 8'h00);
		wr(IDX_CFG3, 8'h01);
		cyc(2);
		`CHK("alert_mode", 1'b1, alert_mode)
		for (int i = 0; i < 12; i++) begin
			if (i == 6)
				continue;
			fault_want <= amttr_fault_t'(12'h1 << i);
			cyc(4);
			`CHK("alert_n", 1'b0, alert_n)
			wr(i > 6 ? IDX_MASK_CH : IDX_MASK_FLT, 8'h1 << mb[i]);
			cyc(3);
			`CHK("alert_n", 1'b1, alert_n)
			wr(i > 6 ? IDX_MASK_CH : IDX_MASK_FLT, 8'h00);
		end
		fault_want <= amttr_fault_t'(12'h03c);
		wr(IDX_MASK_CH, 8'h80);
		cyc(3);
		`CHK("alert_n", 1'b1, alert_n)
		wr(IDX_MASK_CH, 8'h00);
		fault_want <= amttr_fault_t'(12'h040);
		wr(IDX_MASK_FLT, 8'hff);
		cyc(4);
		`CHK("alert_n", 1'b0, alert_n)
		wr(IDX_CFG3, 8'h00);
		cyc(3);
		`CHK("alert_n", 1'b1, alert_n)
		fault_want <= '0;
		wr(IDX_MASK_FLT, 8'h00);
		m0 = amttr_meas_t'({$urandom(), $urandom()});
		m1 = amttr_meas_t'({$urandom(), $urandom()});
		meas_want <= m0;
		cyc(3);
		rd(IDX_VOLT_LOW, {26'h0, m0[1][1:0], m0[0][1:0], 2'h0}, 32'h3c);
		meas_want <= m1;
		cyc(3);
		rd(IDX_HIGH_BASE, {24'h0, m0[0][9:2]}, 32'hff);
		rd(IDX_HIGH_BASE + 8'h1, {24'h0, m0[1][9:2]}, 32'hff);
		cyc(2);
		rd(IDX_HIGH_BASE, {24'h0, m1[0][9:2]}, 32'hff);
		rd(IDX_TEMP_LOW, {24'h0, m1[4][1:0], m1[3][1:0], m1[2][1:0],
			2'h0}, 32'hfc);
		meas_want <= m0;
		cyc(3);
		for (int c = 2; c < 5; c++)
			rd(IDX_HIGH_BASE + 8'(c), {24'h0, m1[c][9:2]}, 32'hff);
		v = {4'($urandom()), 4'h7};
		wr(IDX_CFG3, v);
		rd(IDX_CFG3, {24'h0, v}, 32'hff);
		`CHK("fast", 1'b0, fan_ctl.fast)
		`CHK("steady", v[7:4], fan_ctl.steady_drive)
		tach_period(n);
		`CHK("tach slow", 32, n)
		v[3] = 1'b1;
		wr(IDX_CFG3, v);
		tach_period(n);
		`CHK("tach fast", 8, n)
		wr(IDX_CTRL, 8'h03);
		wr(IDX_CFG3, ~v);
		rd(IDX_CFG3, {24'h0, v}, 32'hff);
		wr(IDX_LIMIT, 8'h02);
		pin_want_n <= 1'b0;
		cyc(22);
		`CHK("boost", 1'b1, fan_ctl.boost)
		pin_want_n <= 1'b1;
		cyc(4);
		`CHK("boost", 1'b0, fan_ctl.boost)
		`CHK("alert_n", 1'b0, alert_n)
		rd(IDX_DURATION, 32'h05, 32'hff);
		rd(IDX_DURATION, 32'h00, 32'hff);
		wr(IDX_MASK_FLT, 8'h20);
		cyc(3);
		`CHK("alert_n", 1'b1, alert_n)
		rd(IDX_EVENT, 32'h1, 32'h1);
		rd(IDX_EVENT, 32'h0, 32'h1);
		pin_want_n <= 1'b0;
		cyc(6);
		pin_want_n <= 1'b1;
		cyc(3);
		rd(IDX_DURATION, 32'h01, 32'hff);
		rd(IDX_DURATION, 32'h00, 32'hff);
		rd(IDX_EVENT, 32'h0, 32'h1);
		wr(IDX_LIMIT, 8'h00);
		pin_want_n <= 1'b0;
		cyc(2);
		pin_want_n <= 1'b1;
		cyc(3);
		rd(IDX_EVENT, 32'h1, 32'h1);
		cyc(2);
		test_done();
	end
endmodule : amttr_regs_tb
